/* icr_regs.svh */
// Constants for the I/O card identity and reset register decode.
// Assumes inclusion by the design modules by bare name; the package does not include it.
`ifndef ICR_REGS_SVH
`define ICR_REGS_SVH
`define ICR_IO_WIN_LO      24'h600000
`define ICR_IO_WIN_HI      24'h800000
`define ICR_OFS_IDENT      16'h0001
`define ICR_OFS_CTRL       16'h0003
`define ICR_RESET_DATA     8'h80
`define ICR_ID_RL_BIT      7
`define ICR_ID_EXT_MSB     6
`define ICR_ID_EXT_LSB     5
`define ICR_ID_BASE_MSB    4
`define ICR_CTRL_IE_BIT    7
`define ICR_CTRL_DE1_BIT   1
`define ICR_CTRL_DE0_BIT   0
`define ICR_RST_PULSE_NS   100
`define ICR_CLK_NS         10
`define ICR_RST_PULSE_CYC  ((`ICR_RST_PULSE_NS + `ICR_CLK_NS - 1) / `ICR_CLK_NS)
`endif

/* icr_pkg.sv */
// Types shared by the I/O card register decode.
// Assumes the constants header sits in the same folder.
package icr_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_WAIT_END} icr_bus_e;
  typedef struct packed {
    logic [22:0] addr;
    logic        as;
    logic        lds;
    logic        rd;
    logic [7:0]  wdata;
  } icr_req_s;
  typedef struct packed {
    logic       ie;
    logic       de1;
    logic       de0;
  } icr_ctrl_s;
endpackage : icr_pkg

/* icr_decode.sv */
// Address decode for one card window on the asynchronous backplane.
// Assumes a 23-bit word address and a 64 KB card region selected by code.
`timescale 1ns/1ps
module icr_decode
  import icr_pkg::*;
#(
  parameter int unsigned SEL_W = 5
) (
  // Request
  input  wire logic [22:0]      i_addr,
  input  wire logic [SEL_W-1:0] i_sel_code,
  // Decode results
  output logic                  o_in_region,
  output logic [15:0]           o_offset
);
  `include "icr_regs.svh"
  logic [23:0] byte_addr;
  logic [23:0] base;
  always_comb begin
    byte_addr = {i_addr, 1'b1};
    base      = `ICR_IO_WIN_LO + 24'({i_sel_code, 16'h0000});
    // Only the upper bits are compared; the full 16-bit offset goes out for register decode.
    o_in_region = (byte_addr >= `ICR_IO_WIN_LO) &&
                  (byte_addr < `ICR_IO_WIN_HI) &&
                  (byte_addr[23:16] == base[23:16]);
    o_offset    = byte_addr[15:0];
  end
endmodule : icr_decode

/* icr_card_regs.sv */
// Identity and card reset registers of a backplane I/O card.
// Assumes bus strobes already synchronous to i_ref_clk and active high here.
`timescale 1ns/1ps
// Operation
// - Registers on low data byte, odd offsets
// - Aliasing allowed, never outside own region
// - Extra registers only supplement fixed ones
// - Offset 1 read returns identity byte
// - Write to offset 1 resets card
// - Master writes 80h; value ignored
// - Controller-chip command reset may replace it
// - No backplane clock; interlocked handshake only
// - Decode lies inside 600000h to 800000h
// - Card reset clears interrupt and DMA enables
// - Remote flag one only for remote-capable cards
// - Identity bits hardwired, not switch-selected
module icr_card_regs
  import icr_pkg::*;
#(
  parameter int unsigned SEL_W     = 5,
  parameter logic        REMOTE_OK = 1'b0,
  parameter logic [1:0]  EXT_ID    = 2'h0,
  parameter logic [4:0]  BASE_CODE = 5'h01
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst_b,
  // Backplane request
  input  wire logic [22:0]      i_addr,
  input  wire logic             i_address_strobe,
  input  wire logic             i_lower_byte_strobe,
  input  wire logic             i_read_write_select,
  input  wire logic [7:0]       i_wdata,
  input  wire logic [SEL_W-1:0] i_sel_code,
  // Backplane answer
  output logic                  o_dtack,
  output logic                  o_addressed,
  output logic [7:0]            o_rdata,
  output logic                  o_rdata_oe,
  // Card state
  output logic                  o_card_reset,
  output logic                  o_interrupt_enable_bit,
  output logic                  o_dma_chan0_enable,
  output logic                  o_dma_chan1_enable
);
  `include "icr_regs.svh"
  localparam logic [7:0] RST_CYC = 8'(`ICR_RST_PULSE_CYC);

  // A wider select code would run past the end of the external window.
  if (SEL_W < 1 || SEL_W > 5) begin : g_bad_sel_w
    $error("SEL_W must be 1 to 5");
  end
  // The pulse counter is eight bits wide.
  if (`ICR_RST_PULSE_CYC < 1 || `ICR_RST_PULSE_CYC > 255) begin : g_bad_rst
    $error("Reset pulse count must be 1 to 255");
  end

  typedef struct packed {
    icr_bus_e   st;
    icr_ctrl_s  ctrl;
    logic [7:0] rst_cnt;
    logic       dtack;
    logic       addressed;
    logic [7:0] rdata;
    logic       oe;
    logic       crst;
  } state_s;

  localparam state_s Q_RESET = '{
    st:        ST_IDLE,
    ctrl:      '0,
    rst_cnt:   8'h00,
    dtack:     1'b0,
    addressed: 1'b0,
    rdata:     8'h00,
    oe:        1'b0,
    crst:      1'b0
  };

  state_s      q;
  state_s      d;
  icr_req_s    req;
  logic        in_region;
  logic [15:0] offset;
  logic [7:0]  ident;
  logic [7:0]  status;
  logic        hit;
  logic        rd_hit;
  logic        wr_ident;
  logic        wr_ctrl;
  logic [7:0]  rd_value;

  icr_decode #(.SEL_W(SEL_W)) u_dec (
    .i_addr      (req.addr),
    .i_sel_code  (i_sel_code),
    .o_in_region (in_region),
    .o_offset    (offset)
  );

  always_comb begin
    req.addr  = i_addr;
    req.as    = i_address_strobe;
    req.lds   = i_lower_byte_strobe;
    req.rd    = i_read_write_select;
    req.wdata = i_wdata;
  end

  // Tie-offs keep the identity fixed regardless of any select switch.
  always_comb begin
    ident                                  = 8'h00;
    ident[`ICR_ID_RL_BIT]                  = REMOTE_OK;
    ident[`ICR_ID_EXT_MSB:`ICR_ID_EXT_LSB] = EXT_ID;
    ident[`ICR_ID_BASE_MSB:0]              = BASE_CODE;
  end

  // Undefined status bits read as zero so software can mask them safely.
  always_comb begin
    status                    = 8'h00;
    status[`ICR_CTRL_IE_BIT]  = q.ctrl.ie;
    status[`ICR_CTRL_DE1_BIT] = q.ctrl.de1;
    status[`ICR_CTRL_DE0_BIT] = q.ctrl.de0;
  end

  // Only the low byte strobe selects registers here.
  // Offsets are fully decoded inside the region; the decode keeps them out of others.
  always_comb begin
    hit      = req.as && req.lds && in_region && offset[0];
    rd_hit   = hit && req.rd;
    wr_ident = hit && !req.rd && (offset == `ICR_OFS_IDENT);
    wr_ctrl  = hit && !req.rd && (offset == `ICR_OFS_CTRL);
  end

  // Unmapped odd offsets still answer, with zero, so the master never hangs.
  always_comb begin
    unique case (offset)
      `ICR_OFS_IDENT: rd_value = ident;
      `ICR_OFS_CTRL:  rd_value = status;
      default:        rd_value = 8'h00;
    endcase
  end

  // The pulse counter runs beside the bus machine, so a cycle that fires
  // the card reset still completes its handshake.
  always_comb begin
    d      = q;
    d.crst = (q.rst_cnt != 8'h00);
    if (q.rst_cnt != 8'h00) begin
      d.rst_cnt = q.rst_cnt - 8'h01;
    end
    unique case (q.st)
      ST_IDLE: begin
        if (hit) begin
          d.st        = ST_ACK;
          d.addressed = 1'b1;
        end
        if (rd_hit) begin
          d.oe    = 1'b1;
          d.rdata = rd_value;
        end
        // With no controller command sequence on the card, this write is
        // the only way software restores the power-on state.
        if (wr_ident) begin
          // Data value is ignored; any write restores power-on state.
          d.rst_cnt = RST_CYC;
          d.crst    = 1'b1;
          d.ctrl    = '0;
        end
        if (wr_ctrl) begin
          d.ctrl.ie  = req.wdata[`ICR_CTRL_IE_BIT];
          d.ctrl.de1 = req.wdata[`ICR_CTRL_DE1_BIT];
          d.ctrl.de0 = req.wdata[`ICR_CTRL_DE0_BIT];
        end
      end
      ST_ACK: begin
        d.dtack = 1'b1;
        d.st    = ST_WAIT_END;
      end
      ST_WAIT_END: begin
        // Hold the answer until the master drops its strobe.
        if (!req.as) begin
          d.st        = ST_IDLE;
          d.dtack     = 1'b0;
          d.addressed = 1'b0;
          d.oe        = 1'b0;
          d.rdata     = 8'h00;
        end
      end
      default: begin
        // An illegal state code drops the answer and returns to idle.
        d.st        = ST_IDLE;
        d.dtack     = 1'b0;
        d.addressed = 1'b0;
        d.oe        = 1'b0;
        d.rdata     = 8'h00;
      end
    endcase
  end

  // Reset loads constants only; the card reset pulse never feeds back here.
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q <= Q_RESET;
    end else begin
      q <= d;
    end
  end

  // Every output is a plain copy of a flop.
  always_comb begin
    o_dtack                = q.dtack;
    o_addressed            = q.addressed;
    o_rdata                = q.rdata;
    o_rdata_oe             = q.oe;
    o_card_reset           = q.crst;
    o_interrupt_enable_bit = q.ctrl.ie;
    o_dma_chan0_enable     = q.ctrl.de0;
    o_dma_chan1_enable     = q.ctrl.de1;
  end
endmodule : icr_card_regs

/* icr_card_regs_props.sv */
// Checker for the card identity and reset register decode.
// Assumes it is bound to icr_card_regs and sees only its ports.
`timescale 1ns/1ps
module icr_card_regs_props (
  // Clock, reset and request
  input wire logic        i_ref_clk, i_rst_b, i_address_strobe,
  input wire logic        i_lower_byte_strobe, i_read_write_select,
  input wire logic [22:0] i_addr,
  // Answer and card state
  input wire logic        o_dtack, o_addressed, o_rdata_oe, o_card_reset,
  input wire logic        o_interrupt_enable_bit, o_dma_chan0_enable,
  input wire logic        o_dma_chan1_enable,
  input wire logic [7:0]  o_rdata
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  property p_ack; $rose(o_dtack) |-> $past(o_addressed); endproperty
  property p_lane; $rose(o_addressed) |-> $past(i_lower_byte_strobe);
  endproperty
  property p_win; $rose(o_addressed) |-> $past(i_addr[22:20]) == 3'h3;
  endproperty
  property p_dir; $rose(o_rdata_oe) |-> $past(i_read_write_select);
  endproperty
  property p_rel; $fell(i_address_strobe) |=>
    !o_dtack && !o_addressed && !o_rdata_oe; endproperty
  property p_clr; $rose(o_card_reset) |-> !o_interrupt_enable_bit &&
    !o_dma_chan0_enable && !o_dma_chan1_enable; endproperty
  property p_len; $rose(o_card_reset) |->
    o_card_reset[*8] ##1 o_card_reset[*3] ##1 !o_card_reset; endproperty
  property p_cause; $rose(o_card_reset) |-> $past(i_address_strobe &&
    i_lower_byte_strobe && !i_read_write_select &&
    i_addr[14:0] == 15'h0000); endproperty
  property p_idle; !o_rdata_oe |-> o_rdata == 8'h00; endproperty
  a_ack: assert property (p_ack) else $error("ack early");
  a_lane: assert property (p_lane) else $error("wrong lane");
  a_win: assert property (p_win) else $error("out of window");
  a_dir: assert property (p_dir) else $error("drove on write");
  a_rel: assert property (p_rel) else $error("answer held");
  a_clr: assert property (p_clr) else $error("enable kept");
  a_len: assert property (p_len) else $error("pulse length");
  a_cause: assert property (p_cause) else $error("stray reset");
  a_idle: assert property (p_idle) else $error("idle data");
endmodule : icr_card_regs_props

/* icr_master.sv */
// Bus master model: one interlocked byte cycle per call.
// Assumes the bench calls xfer just after a rising edge.
`timescale 1ns/1ps
module icr_master (
  // Clock and card answer
  input  wire logic        i_clk,
  input  wire logic        i_dtack,
  input  wire logic [7:0]  i_rdata,
  // Request
  output logic [22:0] o_addr = 23'h0,
  output logic        o_as = 1'b0, o_lds = 1'b0, o_rw = 1'b1,
  output logic [7:0]  o_wdata = 8'h00
);
  task automatic xfer(input logic [22:0] a, input logic l, r,
                      input logic [7:0] d, output logic [7:0] q,
                      output logic ack);
    ack = 1'b0;
    q = 8'h00;
    o_addr = a;
    o_lds = l;
    o_rw = r;
    o_wdata = d;
    o_as = 1'b1;
    // Held until an edge samples the acknowledge, for at most 10 edges; no clock crosses.
    for (int n = 0; n < 10 && !ack; n++) begin
      @(posedge i_clk);
      ack = i_dtack;
      q = i_rdata;
    end
    #1;
    o_as = 1'b0;
    o_lds = 1'b0;
    // Released lines float, so show the inverse of the last value.
    o_addr = ~a;
    o_wdata = ~d;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : xfer
endmodule : icr_master

/* icr_card_regs_tb.sv */
// Self-checking bench for the card identity and reset registers.
// Assumes the card sits at region select 2, word base 310000h.
`timescale 1ns/1ps
`define CHK(n,e,a) begin n_checks++; if ((e) !== (a)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module icr_card_regs_tb;
  logic ref_clk = 0, rst_b = 0, stb, lstb, rw, dtack, adr, oe, crst;
  logic ie, de0, de1, ack, ea, ecr;
  logic [22:0] addr;
  logic [7:0] wd, rdata, q, wo, ed, d;
  logic [1:0] rl;
  int n_mismatch = 0, n_checks = 0;
  logic [26:0] rows [7] = '{{8'h00,2'h3,8'h00,1'h1,8'h01},
    {8'h01,2'h1,8'h83,1'h1,8'h00}, {8'h01,2'h3,8'h00,1'h1,8'h83},
    {8'h00,2'h1,8'h80,1'h1,8'h00}, {8'h01,2'h3,8'h00,1'h1,8'h00},
    {8'h00,2'h2,8'h00,1'h0,8'h00}, {8'h40,2'h3,8'h00,1'h1,8'h00}};
  always #5 ref_clk = ~ref_clk;
  icr_master icr_master_i (.i_clk(ref_clk), .i_dtack(dtack), .i_rdata(rdata),
    .o_addr(addr), .o_as(stb), .o_lds(lstb), .o_rw(rw), .o_wdata(wd));
  icr_card_regs icr_card_regs_i (.i_ref_clk(ref_clk), .i_rst_b(rst_b),
    .i_addr(addr), .i_address_strobe(stb), .i_lower_byte_strobe(lstb),
    .i_read_write_select(rw), .i_wdata(wd), .i_sel_code(5'h02),
    .o_dtack(dtack), .o_addressed(adr), .o_rdata(rdata), .o_rdata_oe(oe),
    .o_card_reset(crst), .o_interrupt_enable_bit(ie),
    .o_dma_chan0_enable(de0), .o_dma_chan1_enable(de1));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  initial begin
    #50us;
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    foreach (rows[k]) begin
      {wo, rl, d, ea, ed} = rows[k];
      icr_master_i.xfer(23'h310000 + 23'(wo), rl[0], rl[1], d, q, ack);
      `CHK("ack", ea, ack)
      if (rl[1]) `CHK("rdata", ed, q)
      ecr = !rl[1] && rl[0] && wo == 8'h00;
      `CHK("idle", {3'h0, ecr}, {dtack, adr, oe, crst})
      repeat (12) @(posedge ref_clk);
      #1 $display("row %0d done", k);
    end
    // Outside the selected region nothing may answer.
    icr_master_i.xfer(23'h300000, 1'b1, 1'b1, 8'h00, q, ack);
    `CHK("foreign", 1'b0, ack)
    icr_master_i.xfer(23'h310001, 1'b1, 1'b0, 8'h83, q, ack);
    `CHK("enables", 3'h7, {ie, de1, de0})
    rst_b = 1'b0;
    @(posedge ref_clk);
    `CHK("pin reset", 3'h0, {ie, de1, de0})
    #1 rst_b = 1'b1;
    icr_master_i.xfer(23'h310000, 1'b1, 1'b1, 8'h00, q, ack);
    `CHK("id after reset", 9'h101, {ack, q})
    icr_master_i.xfer(23'h310001, 1'b1, 1'b0, 8'h83, q, ack);
    icr_master_i.xfer(23'h310000, 1'b1, 1'b0, 8'h00, q, ack);
    `CHK("strobe reset", 4'h8, {crst, ie, de1, de0})
    repeat (12) @(posedge ref_clk);
    #1;
    `CHK("reset ended", 1'b0, crst)
    $display("reset tests done");
    tally_and_finish();
  end
endmodule : icr_card_regs_tb
bind icr_card_regs icr_card_regs_props icr_card_regs_props_i (.i_ref_clk,
  .i_rst_b, .i_address_strobe, .i_lower_byte_strobe, .i_read_write_select,
  .i_addr, .o_dtack, .o_addressed, .o_rdata_oe, .o_card_reset, .o_rdata,
  .o_interrupt_enable_bit, .o_dma_chan0_enable, .o_dma_chan1_enable);
